// file: inc/rx_path_regs.vh
// register offsets, field positions, reset values and counts of the path block
`ifndef RX_PATH_REGS_VH
`define RX_PATH_REGS_VH
// register byte offsets
`define OFF_CFG 8'h00
`define OFF_STAT 8'h04
`define OFF_EVT 8'h08
`define OFF_PTR 8'h0C
`define OFF_CMD 8'h10
`define OFF_B3H 8'h14
`define OFF_FEBEH 8'h18
// configuration fields
`define CFG_SS 0
`define CFG_SPACE 1
`define CFG_ILLEGAL 2
`define CFG_RDI_LONG 3
`define CFG_RESET 4'h7
// event bit positions
`define EV_INV 0
`define EV_BADNDF 1
`define EV_NEW 2
`define EV_JUMP 3
`define EV_ILLEGAL 4
`define EV_INC 5
`define EV_DEC 6
`define EV_NDF 7
`define EV_AIS 8
// pointer and frame figures
`define OFF_MAX 10'h30E
`define SS_SDH 2'h2
`define AIS_N 4'h3
`define INV_N 4'h8
`define NDF_N 4'h8
`define NEW_N 4'h3
`define SPACING 3'h3
`define FAR_END_ERROR_COUNT_MAX 4'h8
`define SPE_COLS 7'h57
`define POH_ROWS 4'h9
`define ROW_B3 4'h1
`define ROW_G1 4'h3
`define RDI_SHORT 4'h5
`define RDI_LONG 4'hA
`endif

// file: design/remote_defect_filter.v
// persistence filter for one remote defect bit of the path status byte
`default_nettype none
module remote_defect_filter (
    input wire pclk,
    input wire presetn,
    input wire sample,
    input wire bit_in,
    input wire long_sel,
    output reg defect_q
);
`include "rx_path_regs.vh"
    reg [3:0] run_q; // frames that disagree with the present verdict
    wire [3:0] need = long_sel ? `RDI_LONG : `RDI_SHORT;

    // flip the verdict after need disagreeing frames in a row
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 4'h0;
            defect_q <= 1'b0;
        end else if (sample) begin
            if (bit_in == defect_q) begin
                run_q <= 4'h0; // agreement breaks the run
            end else if (run_q + 4'h1 >= need) begin
                run_q <= 4'h0;
                defect_q <= bit_in;
            end else begin
                run_q <= run_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: design/poh_serialiser.v
// path overhead byte store and serial output paced by the overhead clock
`default_nettype none
module poh_serialiser (
    input wire pclk,
    input wire presetn,
    input wire link_clk,
    input wire load,
    input wire [3:0] load_idx,
    input wire [7:0] load_byte,
    output reg ser_q,
    output reg mark_q
);
`include "rx_path_regs.vh"
    reg [7:0] mem [0:8]; // nine overhead bytes of the latest frame
    integer j; // store row
    reg s1_q; // first sync stage, read only by s2_q
    reg s2_q;
    reg s3_q; // delayed copy for edge finding
    reg [3:0] rd_q; // byte being shifted
    reg [2:0] bit_q; // bit being shifted, 0 is msb
    wire fall = s3_q & ~s2_q;

    // store bytes, sync the overhead clock and shift on its fall
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (j = 0; j < `POH_ROWS; j = j + 1) begin
                mem[j] <= 8'h00; // line reads 0 until loaded
            end
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            rd_q <= 4'h0;
            bit_q <= 3'h0;
            ser_q <= 1'b0;
            mark_q <= 1'b0;
        end else begin
            if (load && load_idx < `POH_ROWS) begin
                mem[load_idx] <= load_byte;
            end
            s1_q <= link_clk;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (fall) begin
                ser_q <= mem[rd_q][3'h7 - bit_q];
                mark_q <= (rd_q == 4'h0) && (bit_q == 3'h0);
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    rd_q <= (rd_q == `POH_ROWS - 4'h1) ? 4'h0 : rd_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: design/receive_path_pointer_processor.v
// receive path pointer interpreter, timeslot, error monitor and apb regs
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`default_nettype none
// Behaviour
// - five flag codes count as enabled
// - five flag codes count as disabled
// - other six codes: invalid pointer, bad flag
// - enabled flag, size ok, offset in range
// - disabled flag, size ok, offset equals active
// - both pointer bytes all ones: alarm indication
// - inc/dec by majority, spaced over three frames
// - new offset in range, also invalid
// - size bits 10, checking optional
// - three alarm indications enter alarm state
// - eight invalid or enabled enter pointer loss
// - three equal new pointers win over eight
// - three equal pointers clear pointer loss
// - alarm clears on three equal or enabled
// - state change clears all run counters
// - third equal new: jump, load, readable
// - flag close inc/dec as illegal, optional
// - timeslot counter aligned by first envelope byte
// - two 16-bit error counters, latched on command
// - far-end field above eight counts zero
// - remote defect bits filtered five or ten
// - overhead serial out on overhead clock fall
module receive_path_pointer_processor (
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ptr_valid,
    input wire [7:0] ptr_h1,
    input wire [7:0] ptr_h2,
    input wire spe_valid,
    input wire [7:0] spe_byte,
    input wire spe_j1,
    input wire path_overhead_clock,
    output reg pointer_loss,
    output reg path_alarm_out,
    output reg alignment_jump_event,
    output wire path_remote_defect,
    output wire aux_path_remote_defect,
    output reg poh_mark,
    output reg payload_mark,
    output wire path_overhead_serial_out,
    output wire path_overhead_frame_mark
);
`include "rx_path_regs.vh"
    // one-hot pointer states
    localparam [2:0] ST_NORM = 3'b001;
    localparam [2:0] ST_ALARM = 3'b010;
    localparam [2:0] ST_LOST = 3'b100;

    // count of set bits in a byte
    function [3:0] pop8;
        input [7:0] v;
        integer k;
        begin
            pop8 = 4'h0;
            for (k = 0; k < 8; k = k + 1) begin
                pop8 = pop8 + {3'h0, v[k]};
            end
        end
    endfunction

    // saturating add of a small count to a 16-bit counter
    function [15:0] sat_add;
        input [15:0] a;
        input [3:0] b;
        reg [16:0] s;
        begin
            s = {1'b0, a} + {13'h0, b};
            sat_add = s[16] ? 16'hFFFF : s[15:0];
        end
    endfunction

    reg [2:0] state_q; // pointer state
    reg [2:0] state_d;
    reg [9:0] active_q; // accepted offset
    reg [9:0] active_d;
    reg act_ok_q; // active offset defined
    reg act_ok_d;
    reg [3:0] cnt_ais_q; // consecutive run counters
    reg [3:0] cnt_inv_q;
    reg [3:0] cnt_ndf_q;
    reg [3:0] cnt_new_q;
    reg [9:0] new_off_q; // offset of the new pointer run
    reg [2:0] since_q; // frames since last ndf/inc/dec
    reg jump_d;
    reg [3:0] cfg_q; // configuration register
    reg [8:0] ev_q; // sticky event flags
    reg [15:0] b3_cnt_q; // running error counters
    reg [15:0] far_end_error_count_cnt_q;
    reg [15:0] b3_hold_q; // latched copies
    reg [15:0] far_end_error_count_hold_q;
    reg [7:0] par_q; // parity of the frame in progress
    reg [7:0] last_par_q; // parity of the previous frame
    reg [6:0] col_q; // timeslot column of next byte
    reg [3:0] row_q; // timeslot row of next byte
    reg [31:0] rd_d;
    reg hit_d;

    // pointer fields
    wire [3:0] nib = ptr_h1[7:4];
    wire [9:0] off = {ptr_h1[1:0], ptr_h2};
    wire ndf_on = nib == 4'h9 || nib == 4'h1 || nib == 4'hD ||
        nib == 4'hB || nib == 4'h8;
    wire ndf_off = nib == 4'h6 || nib == 4'hE || nib == 4'h2 ||
        nib == 4'h4 || nib == 4'h7;
    wire ss_ok = !cfg_q[`CFG_SS] || ptr_h1[3:2] == `SS_SDH;
    wire in_rng = off <= `OFF_MAX;
    wire same = act_ok_q && off == active_q;
    wire [9:0] flip = off ^ active_q;
    wire i_maj = pop8({3'h0, flip[9], flip[7], flip[5], flip[3],
        flip[1]}) >= 4'h3;
    wire d_maj = pop8({3'h0, flip[8], flip[6], flip[4], flip[2],
        flip[0]}) >= 4'h3;
    wire spaced = since_q >= `SPACING;
    wire dis_ok = ndf_off && ss_ok;
    // indications of this frame
    wire e_ais = ptr_h1 == 8'hFF && ptr_h2 == 8'hFF;
    wire e_ndf = ndf_on && ss_ok && in_rng;
    wire e_norm = dis_ok && same;
    wire raw_inc = dis_ok && act_ok_q && i_maj && !d_maj;
    wire raw_dec = dis_ok && act_ok_q && d_maj && !i_maj;
    wire e_inc = raw_inc && (spaced || !cfg_q[`CFG_SPACE]);
    wire e_dec = raw_dec && (spaced || !cfg_q[`CFG_SPACE]);
    wire e_inv = !(e_norm || e_ndf || e_ais || e_inc || e_dec);
    wire e_new = dis_ok && in_rng && !same && !e_inc && !e_dec;
    wire e_bad = !ndf_on && !ndf_off;
    wire e_ill = (raw_inc || raw_dec) && !spaced &&
        cfg_q[`CFG_ILLEGAL];
    wire eq_new = e_new && cnt_new_q != 4'h0 && off == new_off_q;
    wire eq3 = eq_new && cnt_new_q == `NEW_N - 4'h1;
    wire inv8 = e_inv && cnt_inv_q == `INV_N - 4'h1;
    wire ais3 = e_ais && cnt_ais_q == `AIS_N - 4'h1;
    wire ndf8 = e_ndf && cnt_ndf_q == `NDF_N - 4'h1;
    wire chg = state_d != state_q;

    // next pointer state and offset, three equal new pointers first
    always @* begin
        state_d = state_q;
        active_d = active_q;
        act_ok_d = act_ok_q;
        jump_d = 1'b0;
        if (ptr_valid) begin
            case (state_q)
                ST_NORM: begin
                    if (eq3) begin
                        active_d = off;
                        jump_d = 1'b1;
                    end else if (inv8 || ndf8) begin
                        state_d = ST_LOST;
                    end else if (ais3) begin
                        state_d = ST_ALARM;
                    end else if (e_ndf) begin
                        active_d = off;
                    end else if (e_inc) begin
                        active_d = (active_q == `OFF_MAX) ? 10'h000 :
                            active_q + 10'h001;
                    end else if (e_dec) begin
                        active_d = (active_q == 10'h000) ? `OFF_MAX :
                            active_q - 10'h001;
                    end
                end
                ST_ALARM: begin
                    if (eq3 || e_ndf) begin
                        state_d = ST_NORM;
                        active_d = off;
                        jump_d = eq3;
                    end else if (inv8) begin
                        state_d = ST_LOST;
                    end
                end
                ST_LOST: begin
                    if (eq3) begin
                        state_d = ST_NORM;
                        active_d = off;
                        jump_d = 1'b1;
                    end else if (ais3) begin
                        state_d = ST_ALARM;
                    end
                end
                default: begin
                    state_d = ST_LOST;
                end
            endcase
            act_ok_d = state_d == ST_NORM;
        end
    end

    // pointer state, offset and consecutive run counters
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_LOST;
            active_q <= 10'h000;
            act_ok_q <= 1'b0;
            cnt_ais_q <= 4'h0;
            cnt_inv_q <= 4'h0;
            cnt_ndf_q <= 4'h0;
            cnt_new_q <= 4'h0;
            new_off_q <= 10'h000;
            since_q <= `SPACING;
            pointer_loss <= 1'b1;
            path_alarm_out <= 1'b0;
            alignment_jump_event <= 1'b0;
        end else begin
            alignment_jump_event <= jump_d;
            if (ptr_valid) begin
                state_q <= state_d;
                active_q <= active_d;
                act_ok_q <= act_ok_d;
                pointer_loss <= state_d == ST_LOST;
                path_alarm_out <= state_d == ST_ALARM;
                new_off_q <= off;
                if (e_ndf || e_inc || e_dec) begin
                    since_q <= 3'h0;
                end else if (since_q != `SPACING) begin
                    since_q <= since_q + 3'h1;
                end
                if (chg) begin
                    cnt_ais_q <= 4'h0;
                    cnt_inv_q <= 4'h0;
                    cnt_ndf_q <= 4'h0;
                    cnt_new_q <= 4'h0;
                end else begin
                    cnt_ais_q <= e_ais ? cnt_ais_q + 4'h1 : 4'h0;
                    cnt_inv_q <= e_inv ? cnt_inv_q + 4'h1 : 4'h0;
                    cnt_ndf_q <= e_ndf ? cnt_ndf_q + 4'h1 : 4'h0;
                    if (eq3) begin
                        cnt_new_q <= 4'h0; // run restarts after the jump
                    end else if (eq_new) begin
                        cnt_new_q <= cnt_new_q + 4'h1;
                    end else begin
                        cnt_new_q <= e_new ? 4'h1 : 4'h0;
                    end
                end
            end
        end
    end

    // timeslot of the incoming envelope byte
    wire [6:0] cur_col = spe_j1 ? 7'h00 : col_q;
    wire [3:0] cur_row = spe_j1 ? 4'h0 : row_q;
    wire is_poh = cur_col == 7'h00;
    wire poh_byte = spe_valid && is_poh;
    wire b3_byte = poh_byte && cur_row == `ROW_B3;
    wire g1_byte = poh_byte && cur_row == `ROW_G1;
    wire [3:0] b3_err = b3_byte ? pop8(spe_byte ^ last_par_q) : 4'h0;
    wire [3:0] far_end_error_count_err = (g1_byte && spe_byte[7:4] <= `FAR_END_ERROR_COUNT_MAX) ?
        spe_byte[7:4] : 4'h0;

    // free running column and row counter, realigned by j1
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_q <= 7'h00;
            row_q <= 4'h0;
            poh_mark <= 1'b0;
            payload_mark <= 1'b0;
            par_q <= 8'h00;
            last_par_q <= 8'h00;
        end else begin
            poh_mark <= poh_byte;
            payload_mark <= spe_valid && !is_poh;
            if (spe_valid) begin
                if (cur_col == `SPE_COLS - 7'h01) begin
                    col_q <= 7'h00;
                    row_q <= (cur_row == `POH_ROWS - 4'h1) ? 4'h0 :
                        cur_row + 4'h1;
                end else begin
                    col_q <= cur_col + 7'h01;
                    row_q <= cur_row;
                end
                if (spe_j1) begin
                    last_par_q <= par_q;
                    par_q <= spe_byte;
                end else begin
                    par_q <= par_q ^ spe_byte;
                end
            end
        end
    end

    // apb handshake terms
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire wr_cmd = wr && paddr == `OFF_CMD;
    wire [8:0] ev_new = {ptr_valid && e_ais, ptr_valid && e_ndf,
        ptr_valid && e_dec, ptr_valid && e_inc, ptr_valid && e_ill,
        jump_d, ptr_valid && e_new && !eq3, ptr_valid && e_bad,
        ptr_valid && e_inv};
    wire [8:0] ev_clr = (wr && paddr == `OFF_EVT) ? pwdata[8:0] : 9'h000;

    // error counters with latch on command, no event lost in the latch cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b3_cnt_q <= 16'h0000;
            far_end_error_count_cnt_q <= 16'h0000;
            b3_hold_q <= 16'h0000;
            far_end_error_count_hold_q <= 16'h0000;
        end else if (wr_cmd) begin
            b3_hold_q <= b3_cnt_q;
            far_end_error_count_hold_q <= far_end_error_count_cnt_q;
            b3_cnt_q <= sat_add(16'h0000, b3_err);
            far_end_error_count_cnt_q <= sat_add(16'h0000, far_end_error_count_err);
        end else begin
            b3_cnt_q <= sat_add(b3_cnt_q, b3_err);
            far_end_error_count_cnt_q <= sat_add(far_end_error_count_cnt_q, far_end_error_count_err);
        end
    end

    // read mux and address decode
    always @* begin
        rd_d = 32'h0000_0000;
        hit_d = 1'b1;
        case (paddr)
            `OFF_CFG: rd_d[3:0] = cfg_q;
            `OFF_STAT: rd_d[6:0] = {state_q, aux_path_remote_defect,
                path_remote_defect, path_alarm_out, pointer_loss};
            `OFF_EVT: rd_d[8:0] = ev_q;
            `OFF_PTR: rd_d[15:0] = {act_ok_q, 5'h00, active_q};
            `OFF_CMD: rd_d = 32'h0000_0000;
            `OFF_B3H: rd_d[15:0] = b3_hold_q;
            `OFF_FEBEH: rd_d[15:0] = far_end_error_count_hold_q;
            default: hit_d = 1'b0;
        endcase
    end

    // apb slave with one wait state, config and sticky events
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            cfg_q <= `CFG_RESET;
            ev_q <= 9'h000;
        end else begin
            if (psel && penable && !pready) begin
                pready <= 1'b1;
                prdata <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr <= !hit_d;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
            if (wr && paddr == `OFF_CFG) begin
                cfg_q <= pwdata[3:0];
            end
            ev_q <= (ev_q & ~ev_clr) | ev_new;
        end
    end

    // remote defect filters sampled once a frame at the status byte
    remote_defect_filter u_rdi (
        .pclk(pclk),
        .presetn(presetn),
        .sample(g1_byte),
        .bit_in(spe_byte[3]),
        .long_sel(cfg_q[`CFG_RDI_LONG]),
        .defect_q(path_remote_defect)
    );

    remote_defect_filter u_aux_rdi (
        .pclk(pclk),
        .presetn(presetn),
        .sample(g1_byte),
        .bit_in(spe_byte[2]),
        .long_sel(cfg_q[`CFG_RDI_LONG]),
        .defect_q(aux_path_remote_defect)
    );

    // overhead bytes serialised on the overhead clock
    poh_serialiser u_ser (
        .pclk(pclk),
        .presetn(presetn),
        .link_clk(path_overhead_clock),
        .load(poh_byte),
        .load_idx(cur_row),
        .load_byte(spe_byte),
        .ser_q(path_overhead_serial_out),
        .mark_q(path_overhead_frame_mark)
    );
endmodule
`default_nettype wire

// file: test/rx_path_chk.sv
// port checks for the receive path pointer processor
`default_nettype none
module rx_path_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic ptr_valid,
    input wire logic [7:0] ptr_h1,
    input wire logic [7:0] ptr_h2,
    input wire logic spe_valid,
    input wire logic path_overhead_clock,
    input wire logic pointer_loss,
    input wire logic path_alarm_out,
    input wire logic alignment_jump_event,
    input wire logic poh_mark,
    input wire logic payload_mark,
    input wire logic path_overhead_serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic ones; // both pointer bytes all ones
    logic en_ok; // enabled flag, size 10, offset in range
    logic [2:0] ones_q; // run of all-ones frames, saturating
    assign ones = ptr_h1 == 8'hFF && ptr_h2 == 8'hFF;
    assign en_ok = ptr_h1[7:4] inside {4'h9, 4'h1, 4'hD, 4'hB, 4'h8} &&
        ptr_h1[3:2] == 2'h2 && {ptr_h1[1:0], ptr_h2} <= 10'h30E;
    // counts consecutive all-ones frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ones_q <= 3'h0;
        end else if (ptr_valid) begin
            ones_q <= !ones ? 3'h0 : ones_q == 3'h7 ? ones_q : ones_q + 3'h1;
        end
    end
    jump_pulse_a: assert property (alignment_jump_event |=>
        !alignment_jump_event) else $error("jump pulse too long");
    jump_state_a: assert property (alignment_jump_event |->
        !pointer_loss && !path_alarm_out) else $error("jump not in norm");
    lop_cause_a: assert property ($rose(pointer_loss) |->
        $past(ptr_valid) && !$past(ones)) else $error("loss w/o cause");
    ais_count_a: assert property ($rose(path_alarm_out) |->
        ones_q == 3'h3) else $error("alarm not on third all-ones");
    alarm_clear_a: assert property (ptr_valid && path_alarm_out &&
        en_ok |=> !path_alarm_out) else $error("alarm not cleared");
    apb_wait_a: assert property (psel && penable && !pready |=>
        pready ##1 !pready) else $error("apb answer off");
    mark_src_a: assert property (poh_mark |-> $past(spe_valid))
        else $error("overhead mark without byte");
    pay_mark_a: assert property (payload_mark |->
        $past(spe_valid) && !poh_mark) else $error("bad payload mark");
    ser_edge_a: assert property ($changed(path_overhead_serial_out)
        |-> !$past(path_overhead_clock, 3)) else $error("serial off edge");
    cover property ($rose(alignment_jump_event));
    cover property ($rose(path_alarm_out));
    cover property (poh_mark);
endmodule
bind receive_path_pointer_processor rx_path_chk u_chk (.*);
`default_nettype wire

// file: test/upstream_model.sv
// model of the upstream overhead logic feeding pointers and bytes
`default_nettype none
module upstream_model (
    input wire logic pclk,
    output logic ptr_valid,
    output logic [7:0] ptr_h1,
    output logic [7:0] ptr_h2,
    output logic spe_valid,
    output logic [7:0] spe_byte,
    output logic spe_j1
);
    timeunit 1ns;
    timeprecision 1ps;
    // all lines quiet at time zero
    initial begin
        {ptr_valid, spe_valid, spe_j1, ptr_h1, ptr_h2, spe_byte} = '0;
    end
    // one frame: pointer pulse, then optional envelope with g1 on row 3
    task automatic frame(input logic [15:0] p, input logic [7:0] g1,
        input bit spe);
        @(posedge pclk);
        ptr_valid <= 1'b1;
        {ptr_h1, ptr_h2} <= p;
        @(posedge pclk);
        ptr_valid <= 1'b0;
        {ptr_h1, ptr_h2} <= ~p; // released bytes show the inverse
        for (int i = 0; spe && i < 783; i++) begin
            spe_valid <= 1'b1;
            spe_j1 <= i == 0;
            spe_byte <= i == 261 ? g1 : i[7:0];
            @(posedge pclk);
        end
        spe_valid <= 1'b0;
        spe_j1 <= 1'b0;
        spe_byte <= ~spe_byte; // stale byte is not held
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the receive path pointer processor
`default_nettype none
`include "rx_path_regs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    miscompares++; $display("[ERR] %0t got %h want %h", $time, a, b); \
    end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic path_overhead_clock = 1'b1; // free running overhead clock
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    wire [31:0] prdata;
    wire pready, pslverr, pointer_loss, path_alarm_out;
    wire alignment_jump_event, path_remote_defect, aux_path_remote_defect;
    wire poh_mark, payload_mark, path_overhead_serial_out;
    wire path_overhead_frame_mark, ptr_valid, spe_valid, spe_j1;
    wire [7:0] ptr_h1, ptr_h2, spe_byte;
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'heeb5_0c5d; // fixed seed
    logic [9:0] o1, o2; // random pointer offsets
    receive_path_pointer_processor u_dut (.*);
    upstream_model u_up (.*);
    // byte clock and the unrelated overhead clock
    always #2 pclk = ~pclk;
    always #24 path_overhead_clock = ~path_overhead_clock;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // pointer bytes: flag, size bits 10, offset
    function automatic logic [15:0] ptr(input logic [3:0] f,
        input logic [9:0] o);
        return {f, 2'h2, o};
    endfunction
    // flag code to expected event bits 7, 1 and 0
    function automatic logic [31:0] flag_evt(input logic [3:0] c);
        case (c)
            4'h9, 4'h1, 4'hD, 4'hB, 4'h8: return 32'h0000_0080;
            4'h6, 4'hE, 4'h2, 4'h4, 4'h7: return 32'h0000_0000;
            default: return 32'h0000_0003;
        endcase
    endfunction
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        `CHK(q & m, x)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic fr(input logic [15:0] p);
        u_up.frame(p, 8'h00, 1'b0);
    endtask
    // main sequence
    initial begin
        logic [31:0] q;
        logic e;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(pointer_loss, 1'b1)
        rd(`OFF_PTR, 32'h0000_8000, 32'h0000_0000);
        rd(`OFF_STAT, 32'h0000_0073, 32'h0000_0041);
        rd(`OFF_CFG, 32'hFFFF_FFFF, 32'h0000_0007);
        apb(1'b0, 8'h1C, 32'h0000_0000, q, e);
        `CHK({e, q}, 33'h1_0000_0000)
        seed = xs(seed);
        o1 = 10'(1 + seed % 781);
        // three equal new pointers leave pointer loss
        repeat (3) begin
            `CHK(pointer_loss, 1'b1)
            fr(ptr(4'h6, o1));
        end
        `CHK(pointer_loss, 1'b0)
        rd(`OFF_EVT, 32'h0000_000D, 32'h0000_000D);
        rd(`OFF_PTR, 32'h0000_83FF, {16'h0000, 6'h20, o1});
        wr(`OFF_EVT, 32'h0000_01FF);
        // every flag code once at the active offset
        for (int c = 0; c < 16; c++) begin
            fr(ptr(4'(c), o1));
            rd(`OFF_EVT, 32'h0000_0083, flag_evt(4'(c)));
            wr(`OFF_EVT, 32'h0000_01FF);
        end
        `CHK(pointer_loss, 1'b0)
        // increment, too early a second one, then a decrement
        repeat (4) fr(ptr(4'h6, o1));
        fr(ptr(4'h6, o1 ^ 10'h2AA));
        fr(ptr(4'h6, (o1 + 10'h001) ^ 10'h2AA));
        rd(`OFF_PTR, 32'h0000_03FF, {22'h00_0000, o1 + 10'h001});
        rd(`OFF_EVT, 32'h0000_0030, 32'h0000_0030);
        wr(`OFF_EVT, 32'h0000_01FF);
        repeat (4) fr(ptr(4'h6, o1 + 10'h001));
        fr(ptr(4'h6, (o1 + 10'h001) ^ 10'h155));
        rd(`OFF_PTR, 32'h0000_03FF, {22'h00_0000, o1});
        rd(`OFF_EVT, 32'h0000_0040, 32'h0000_0040);
        // broken run of all-ones pointers, then a full run
        repeat (2) fr(16'hFFFF);
        fr(ptr(4'h6, o1));
        repeat (2) fr(16'hFFFF);
        `CHK(path_alarm_out, 1'b0)
        fr(16'hFFFF);
        `CHK({path_alarm_out, pointer_loss}, 2'h2)
        seed = xs(seed);
        o2 = 10'(seed % 783);
        fr(ptr(4'h9, o2));
        `CHK(path_alarm_out, 1'b0)
        // remote defect filter and error counters
        for (int i = 0; i < 10; i++) begin
            u_up.frame(ptr(4'h6, o2), i < 5 ? 8'h3C : 8'h90, 1'b1);
            `CHK(path_remote_defect, i > 3 && i < 9)
            `CHK(aux_path_remote_defect, i > 3 && i < 9)
        end
        wr(`OFF_CMD, 32'h0000_0000);
        rd(`OFF_B3H, 32'h0000_FFFF, 32'h0000_0028);
        rd(`OFF_FEBEH, 32'h0000_FFFF, 32'h0000_000F);
        // reset again in mid-run, then reacquire
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(pointer_loss, 1'b1)
        repeat (3) fr(ptr(4'h6, o2));
        // seven invalid pointers hold, the eighth declares loss
        repeat (7) fr(ptr(4'h0, o2));
        `CHK(pointer_loss, 1'b0)
        fr(ptr(4'h0, o2));
        `CHK(pointer_loss, 1'b1)
        wr(`OFF_CFG, 32'h0000_0006);
        repeat (3) fr({4'h6, 2'h0, o2});
        `CHK(pointer_loss, 1'b0)
        print_verdict();
    end
    // cut a hung run short
    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
